// *** cat_pkg.sv ***
// package: register map, field positions and types of the counter array timer
package cat_pkg;
  localparam int          ADDR_W        = 16;
  localparam logic [15:0] ADDR_MODE     = 16'h00d1;
  localparam logic [15:0] ADDR_CNT_LO   = 16'h00d9;
  localparam logic [15:0] ADDR_FLAGS    = 16'h00e1;
  localparam logic [15:0] ADDR_CNT_HI   = 16'h00e9;
  localparam logic [15:0] ADDR_SNAP_LO  = 16'h00f2;
  localparam logic [15:0] ADDR_SNAP_HI  = 16'h00f3;
  localparam logic [15:0] ADDR_PRESCALE = 16'ha0a5;
  localparam logic [15:0] ADDR_RLD_LO   = 16'ha0a6;
  localparam logic [15:0] ADDR_RLD_HI   = 16'ha0a7;
  localparam logic [7:0]  RESET_BYTE    = 8'h00;
  localparam logic [15:0] RESET_WORD    = 16'h0000;
  localparam logic [7:0]  BYTE_MAX      = 8'hff;
  localparam logic [15:0] WORD_MAX      = 16'hffff;
  localparam logic [15:0] COUNT_STEP    = 16'h0001;
  localparam logic [7:0]  PRESC_STEP    = 8'h01;
  localparam int          NUM_CHANNELS  = 6;

  // mode control byte, bit 7 down to bit 0
  typedef struct packed {
    logic idle_halt_bit;
    logic auto_reload_enable;
    logic byte_width_select;
    logic low_byte_overflow_enable;
    logic counter_enable_bit;
    logic overflow_irq_enable;
    logic compare_irq_enable;
    logic comparator_snapshot_enable;
  } cat_mode_s;

  // flag byte, bit 7 down to bit 0
  typedef struct packed {
    logic       overflow_flag;
    logic       compare_match_flag;
    logic [5:0] channel_flags;
  } cat_flags_s;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } cat_bus_req_s;
endpackage : cat_pkg

// *** cat_main_timer.sv ***
// main time-base counter of the counter array, with byte register port
//
// How it works
// - tick every prescale plus one clocks
// - idle halt bit stops counting in idle
// - reload at overflow, 16 or 8 bit
// - overflow at low byte wrap or full wrap
// - enable clear stops and zeroes count
// - disabled keeps compare stage loaded
// - overflow irq gated by its enable
// - compare irq gated by its enable
// - comparator event snapshots count when enabled
// - overflow flag sticky until software clears
// - compare flag set on count match
// - one sticky flag per channel
// - count bytes read live, writes ignored
// - low count read snapshots full count
// - snapshot reads, compare-value writes
// - compare value double-buffered
// - reload bytes readable and writable
// - count drives channel time base
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
module cat_main_timer
  import cat_pkg::*;
(
  input  wire logic                          core_clk_in,
  input  wire logic                          reset_in,
  input  wire cat_pkg::cat_bus_req_s         bus_req_in,
  output logic [7:0]                         rdata_out,
  input  wire logic                          cpu_idle_in,
  input  wire logic                          comparator_event_in,
  input  wire logic [cat_pkg::NUM_CHANNELS-1:0] channel_irq_in,
  output logic [15:0]                        time_base_out,
  output logic                               overflow_pulse_out,
  output logic                               irq_out
);
  import cat_pkg::*;

  typedef struct packed {
    cat_mode_s   mode;
    cat_flags_s  flags;
    logic [7:0]  prescale;
    logic [7:0]  presc_cnt;
    logic [15:0] count;
    logic [7:0]  rld_lo;
    logic [7:0]  rld_hi;
    logic [15:0] snap;
    logic [15:0] cmp_hold;
    logic [15:0] cmp_active;
    logic [7:0]  rdata;
    logic        ovf_pulse;
  } cat_state_s;

  cat_state_s st;
  cat_state_s next_st;

  logic       tick;
  logic       run;
  logic       ovf;
  logic       match;
  cat_flags_s clr_mask;
  cat_flags_s set_mask;

  // channel flags must fill the rest of the flag byte
  if ($bits(cat_flags_s) != NUM_CHANNELS + 2) begin : g_bad_channel_count
    $error("channel count does not fit the flag byte");
  end

  always_comb begin
    next_st  = st;
    run      = st.mode.counter_enable_bit &&
               !(st.mode.idle_halt_bit && cpu_idle_in);
    // compare as at least, so a smaller prescale written mid-count
    // does not cost a full 256-clock lap
    tick     = run && (st.presc_cnt >= st.prescale);
    // overflow condition on the next increment
    ovf      = tick && (st.mode.low_byte_overflow_enable ?
               (st.count[7:0] == BYTE_MAX) : (st.count == WORD_MAX));
    match    = st.mode.counter_enable_bit &&
               (st.count == st.cmp_active);
    clr_mask = '0;
    set_mask = '0;
    next_st.ovf_pulse = ovf;
    next_st.rdata     = RESET_BYTE;

    // prescaler divides by prescale + 1
    if (!run) begin
      next_st.presc_cnt = RESET_BYTE;
    end else if (tick) begin
      next_st.presc_cnt = RESET_BYTE;
    end else begin
      next_st.presc_cnt = st.presc_cnt + PRESC_STEP;
    end

    if (!st.mode.counter_enable_bit) begin
      next_st.count = RESET_WORD;
    end else if (ovf && st.mode.auto_reload_enable) begin
      if (st.mode.byte_width_select) begin
        next_st.count = {st.count[15:8], st.rld_lo};
      end else begin
        next_st.count = {st.rld_hi, st.rld_lo};
      end
    end else if (tick && st.mode.byte_width_select) begin
      // 8-bit counter leaves the high byte alone; without low-byte
      // overflow set by software the wrap would go unflagged
      next_st.count[7:0] = st.count[7:0] + COUNT_STEP[7:0];
    end else if (tick) begin
      next_st.count = st.count + COUNT_STEP;
    end

    // active compare follows holding stage only at safe moments
    if (!st.mode.counter_enable_bit || ovf) begin
      next_st.cmp_active = st.cmp_hold;
    end

    if (comparator_event_in && st.mode.comparator_snapshot_enable) begin
      next_st.snap = st.count;
    end

    set_mask.overflow_flag      = ovf;
    set_mask.compare_match_flag = match;
    set_mask.channel_flags      = channel_irq_in;

    if (bus_req_in.wr) begin
      unique case (bus_req_in.addr)
        ADDR_MODE:     next_st.mode     = bus_req_in.wdata;
        ADDR_FLAGS:    clr_mask         = ~bus_req_in.wdata;
        ADDR_PRESCALE: next_st.prescale = bus_req_in.wdata;
        ADDR_RLD_LO:   next_st.rld_lo   = bus_req_in.wdata;
        ADDR_RLD_HI:   next_st.rld_hi   = bus_req_in.wdata;
        ADDR_SNAP_LO:  next_st.cmp_hold[7:0]  = bus_req_in.wdata;
        ADDR_SNAP_HI:  next_st.cmp_hold[15:8] = bus_req_in.wdata;
        default: ; // count bytes and unmapped: write ignored
      endcase
    end

    if (bus_req_in.rd) begin
      unique case (bus_req_in.addr)
        ADDR_MODE:     next_st.rdata = st.mode;
        ADDR_FLAGS:    next_st.rdata = st.flags;
        ADDR_CNT_LO: begin
          next_st.rdata = st.count[7:0];
          next_st.snap  = st.count;
        end
        ADDR_CNT_HI:   next_st.rdata = st.count[15:8];
        ADDR_SNAP_LO:  next_st.rdata = st.snap[7:0];
        ADDR_SNAP_HI:  next_st.rdata = st.snap[15:8];
        ADDR_PRESCALE: next_st.rdata = st.prescale;
        ADDR_RLD_LO:   next_st.rdata = st.rld_lo;
        ADDR_RLD_HI:   next_st.rdata = st.rld_hi;
        default:       next_st.rdata = RESET_BYTE;
      endcase
    end

    // set beats clear in the same cycle
    next_st.flags = (st.flags & ~clr_mask) | set_mask;
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign rdata_out          = st.rdata;
  assign time_base_out      = st.count;
  assign overflow_pulse_out = st.ovf_pulse;
  assign irq_out = (st.flags.overflow_flag && st.mode.overflow_irq_enable) ||
                   (st.flags.compare_match_flag &&
                    st.mode.compare_irq_enable);

  property p_ovf_sets_flag;
    @(posedge core_clk_in) disable iff (reset_in)
      ovf |=> st.flags.overflow_flag;
  endproperty
  a_ovf_sets_flag: assert property (p_ovf_sets_flag)
    else $error("overflow did not set flag");

  property p_flag_sticky;
    @(posedge core_clk_in) disable iff (reset_in)
      st.flags.overflow_flag && !bus_req_in.wr |=> st.flags.overflow_flag;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky)
    else $error("overflow flag dropped without write");

  property p_disable_zeroes;
    @(posedge core_clk_in) disable iff (reset_in)
      !st.mode.counter_enable_bit |=> st.count == RESET_WORD;
  endproperty
  a_disable_zeroes: assert property (p_disable_zeroes)
    else $error("count not cleared while disabled");

  property p_disabled_loads_cmp;
    @(posedge core_clk_in) disable iff (reset_in)
      !st.mode.counter_enable_bit |=> st.cmp_active == $past(st.cmp_hold);
  endproperty
  a_disabled_loads_cmp: assert property (p_disabled_loads_cmp)
    else $error("compare stage not loaded while disabled");

  property p_step;
    @(posedge core_clk_in) disable iff (reset_in)
      tick && !ovf |=> st.count == $past(st.count) + COUNT_STEP;
  endproperty
  a_step: assert property (p_step)
    else $error("count did not step by one");

  property p_reload16;
    @(posedge core_clk_in) disable iff (reset_in)
      ovf && st.mode.auto_reload_enable && !st.mode.byte_width_select
      |=> st.count == {$past(st.rld_hi), $past(st.rld_lo)};
  endproperty
  a_reload16: assert property (p_reload16)
    else $error("16-bit reload wrong");

  property p_idle_halt;
    @(posedge core_clk_in) disable iff (reset_in)
      st.mode.idle_halt_bit && cpu_idle_in && st.mode.counter_enable_bit
      && !bus_req_in.wr |=> $stable(st.count);
  endproperty
  a_idle_halt: assert property (p_idle_halt)
    else $error("count moved in idle halt");

  property p_lo_read_snap;
    @(posedge core_clk_in) disable iff (reset_in)
      bus_req_in.rd && bus_req_in.addr == ADDR_CNT_LO
      |=> st.snap == $past(st.count);
  endproperty
  a_lo_read_snap: assert property (p_lo_read_snap)
    else $error("low count read did not snapshot");

  property p_irq_gate;
    @(posedge core_clk_in) disable iff (reset_in)
      irq_out |-> (st.flags.overflow_flag && st.mode.overflow_irq_enable) ||
                  (st.flags.compare_match_flag && st.mode.compare_irq_enable);
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("interrupt without enabled flag");

  property p_match_flag;
    @(posedge core_clk_in) disable iff (reset_in)
      match |=> st.flags.compare_match_flag;
  endproperty
  a_match_flag: assert property (p_match_flag)
    else $error("compare match did not set flag");

  property p_presc_count;
    @(posedge core_clk_in) disable iff (reset_in)
      run && !tick |=> st.presc_cnt == $past(st.presc_cnt) + PRESC_STEP;
  endproperty
  a_presc_count: assert property (p_presc_count)
    else $error("prescaler did not advance");

  property p_tick_reset;
    @(posedge core_clk_in) disable iff (reset_in)
      tick |=> st.presc_cnt == RESET_BYTE;
  endproperty
  a_tick_reset: assert property (p_tick_reset)
    else $error("prescaler did not restart after tick");

  property p_hold_between_ticks;
    @(posedge core_clk_in) disable iff (reset_in)
      st.mode.counter_enable_bit && !tick |=> $stable(st.count);
  endproperty
  a_hold_between_ticks: assert property (p_hold_between_ticks)
    else $error("count moved without a tick");

  property p_reload8;
    @(posedge core_clk_in) disable iff (reset_in)
      ovf && st.mode.auto_reload_enable && st.mode.byte_width_select
      |=> st.count == {$past(st.count[15:8]), $past(st.rld_lo)};
  endproperty
  a_reload8: assert property (p_reload8)
    else $error("8-bit reload wrong");

  property p_free8;
    @(posedge core_clk_in) disable iff (reset_in)
      ovf && !st.mode.auto_reload_enable && st.mode.byte_width_select
      |=> st.count == {$past(st.count[15:8]), RESET_BYTE};
  endproperty
  a_free8: assert property (p_free8)
    else $error("8-bit wrap touched the high byte");

  property p_wrap16;
    @(posedge core_clk_in) disable iff (reset_in)
      ovf && !st.mode.auto_reload_enable && !st.mode.byte_width_select &&
      !st.mode.low_byte_overflow_enable |=> st.count == RESET_WORD;
  endproperty
  a_wrap16: assert property (p_wrap16)
    else $error("16-bit wrap did not reach zero");

  property p_cmp_held;
    @(posedge core_clk_in) disable iff (reset_in)
      st.mode.counter_enable_bit && !ovf |=> $stable(st.cmp_active);
  endproperty
  a_cmp_held: assert property (p_cmp_held)
    else $error("active compare changed while counting");

  property p_ovf_loads_cmp;
    @(posedge core_clk_in) disable iff (reset_in)
      ovf |=> st.cmp_active == $past(st.cmp_hold);
  endproperty
  a_ovf_loads_cmp: assert property (p_ovf_loads_cmp)
    else $error("compare stage not loaded at overflow");

  property p_event_snap;
    @(posedge core_clk_in) disable iff (reset_in)
      comparator_event_in && st.mode.comparator_snapshot_enable
      |=> st.snap == $past(st.count);
  endproperty
  a_event_snap: assert property (p_event_snap)
    else $error("comparator event did not snapshot");

  property p_event_ignored;
    @(posedge core_clk_in) disable iff (reset_in)
      !(comparator_event_in && st.mode.comparator_snapshot_enable) &&
      !(bus_req_in.rd && bus_req_in.addr == ADDR_CNT_LO)
      |=> $stable(st.snap);
  endproperty
  a_event_ignored: assert property (p_event_ignored)
    else $error("snapshot changed without a trigger");

  property p_cnt_hi_read;
    @(posedge core_clk_in) disable iff (reset_in)
      bus_req_in.rd && bus_req_in.addr == ADDR_CNT_HI
      |=> rdata_out == $past(st.count[15:8]);
  endproperty
  a_cnt_hi_read: assert property (p_cnt_hi_read)
    else $error("high count read not live");

  property p_snap_hi_read;
    @(posedge core_clk_in) disable iff (reset_in)
      bus_req_in.rd && bus_req_in.addr == ADDR_SNAP_HI
      |=> rdata_out == $past(st.snap[15:8]);
  endproperty
  a_snap_hi_read: assert property (p_snap_hi_read)
    else $error("snapshot high read wrong");

  property p_cmp_write;
    @(posedge core_clk_in) disable iff (reset_in)
      bus_req_in.wr && bus_req_in.addr == ADDR_SNAP_LO
      |=> st.cmp_hold[7:0] == $past(bus_req_in.wdata);
  endproperty
  a_cmp_write: assert property (p_cmp_write)
    else $error("compare low write did not reach hold stage");

  property p_chan_flags;
    @(posedge core_clk_in) disable iff (reset_in)
      (|channel_irq_in)
      |=> (st.flags.channel_flags & $past(channel_irq_in)) ==
          $past(channel_irq_in);
  endproperty
  a_chan_flags: assert property (p_chan_flags)
    else $error("channel request did not set its flag");

  property p_ovf_clear;
    @(posedge core_clk_in) disable iff (reset_in)
      clr_mask.overflow_flag && !ovf |=> !st.flags.overflow_flag;
  endproperty
  a_ovf_clear: assert property (p_ovf_clear)
    else $error("software write did not clear overflow flag");

  property p_match_only;
    @(posedge core_clk_in) disable iff (reset_in)
      !st.flags.compare_match_flag && !match
      |=> !st.flags.compare_match_flag;
  endproperty
  a_match_only: assert property (p_match_only)
    else $error("compare flag set without a match");

  property p_ovf_only;
    @(posedge core_clk_in) disable iff (reset_in)
      !st.flags.overflow_flag && !ovf |=> !st.flags.overflow_flag;
  endproperty
  a_ovf_only: assert property (p_ovf_only)
    else $error("overflow flag set without overflow");

  property p_pulse;
    @(posedge core_clk_in) disable iff (reset_in)
      ovf |=> overflow_pulse_out;
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("overflow pulse missing");

  property p_rld_read;
    @(posedge core_clk_in) disable iff (reset_in)
      bus_req_in.rd && bus_req_in.addr == ADDR_RLD_HI
      |=> rdata_out == $past(st.rld_hi);
  endproperty
  a_rld_read: assert property (p_rld_read)
    else $error("reload high read wrong");
endmodule : cat_main_timer

// *** counter_array_main_timer_tb.sv ***
// self-checking bench for the counter array main timer
`timescale 1ns/1ps
module counter_array_main_timer_tb;
  import cat_pkg::*;
  logic         clk;
  logic         rst;
  cat_bus_req_s req;
  logic [7:0]   rdata;
  logic         idle;
  logic         cev;
  logic [5:0]   chi;
  logic [15:0]  tb;
  logic         ovf;
  logic         irq;
  int           n_fail;
  int           checks;
  int           cycles;
  logic [15:0]  c0;
  logic [15:0]  amap [10] = '{ADDR_MODE, ADDR_CNT_LO, ADDR_FLAGS,
    ADDR_CNT_HI, ADDR_SNAP_LO, ADDR_SNAP_HI, ADDR_PRESCALE, ADDR_RLD_LO,
    ADDR_RLD_HI, 16'h1234};

  cat_main_timer dut (
    .core_clk_in         (clk),
    .reset_in            (rst),
    .bus_req_in          (req),
    .rdata_out           (rdata),
    .cpu_idle_in         (idle),
    .comparator_event_in (cev),
    .channel_irq_in      (chi),
    .time_base_out       (tb),
    .overflow_pulse_out  (ovf),
    .irq_out             (irq)
  );

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // whole run is well under two thousand cycles
  always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      n_fail = n_fail + 1;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks = checks + 1;
    if (got !== exp) begin
      n_fail = n_fail + 1;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req <= '0;
  endtask : wr

  // read data stands only in the cycle after the strobe
  task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
    @(posedge clk);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req <= '0;
    @(negedge clk);
    chk({8'h00, rdata}, {8'h00, e});
  endtask : rd_chk

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc

  task automatic t_regs();
    foreach (amap[i]) rd_chk(amap[i], 8'h00);
    wr(ADDR_RLD_HI, 8'ha5);
    rd_chk(ADDR_RLD_HI, 8'ha5);
    wr(ADDR_RLD_LO, 8'hf0);
    rd_chk(ADDR_RLD_LO, 8'hf0);
    // compare far above the 8-bit range, loaded while disabled
    wr(ADDR_SNAP_LO, 8'hf0);
    wr(ADDR_SNAP_HI, 8'hff);
  endtask : t_regs

  task automatic t_prescale();
    wr(ADDR_PRESCALE, 8'h02);
    wr(ADDR_MODE, 8'h08);
    cyc(5);
    c0 = tb;
    cyc(30);
    chk(tb - c0, 16'd10);
    wr(ADDR_MODE, 8'h88);
    @(posedge clk) idle <= 1'b1;
    cyc(3);
    c0 = tb;
    cyc(10);
    chk(tb, c0);
    wr(ADDR_MODE, 8'h08);
    cyc(3);
    c0 = tb;
    cyc(30);
    chk(tb - c0, 16'd10);
    @(posedge clk) idle <= 1'b0;
    wr(ADDR_MODE, 8'h00);
    cyc(2);
    chk(tb, 16'h0000);
    wr(ADDR_PRESCALE, 8'h00);
  endtask : t_prescale

  task automatic t_reload();
    int i;
    i = 0;
    wr(ADDR_MODE, 8'hfc);
    do begin
      @(negedge clk);
      i++;
    end while (ovf !== 1'b1 && i < 400);
    chk(tb, 16'h00f0);
    // freeze one step after the reload so the count is known
    @(posedge clk) idle <= 1'b1;
    cyc(2);
    chk(tb, 16'h00f1);
    rd_chk(ADDR_CNT_LO, 8'hf1);
    wr(ADDR_CNT_LO, 8'h55);
    wr(ADDR_CNT_HI, 8'h55);
    rd_chk(ADDR_CNT_LO, 8'hf1);
    rd_chk(ADDR_CNT_HI, 8'h00);
    rd_chk(ADDR_SNAP_LO, 8'hf1);
    rd_chk(ADDR_SNAP_HI, 8'h00);
    rd_chk(ADDR_FLAGS, 8'h80);
    chk({15'h0, irq}, 16'h1);
    wr(ADDR_MODE, 8'hf8);
    cyc(1);
    chk({15'h0, irq}, 16'h0);
    rd_chk(ADDR_FLAGS, 8'h80);
    wr(ADDR_FLAGS, 8'h00);
    rd_chk(ADDR_FLAGS, 8'h00);
  endtask : t_reload

  task automatic t_snap_event(input logic [7:0] m, input logic [7:0] e);
    wr(ADDR_MODE, m);
    @(posedge clk) cev <= 1'b1;
    @(posedge clk) cev <= 1'b0;
    rd_chk(ADDR_SNAP_LO, e);
  endtask : t_snap_event

  task automatic t_compare();
    wr(ADDR_SNAP_LO, 8'h05);
    wr(ADDR_SNAP_HI, 8'h00);
    wr(ADDR_FLAGS, 8'h00);
    wr(ADDR_MODE, 8'h0a);
    cyc(20);
    rd_chk(ADDR_FLAGS, 8'h40);
    chk({15'h0, irq}, 16'h1);
    wr(ADDR_MODE, 8'h08);
    cyc(1);
    chk({15'h0, irq}, 16'h0);
    wr(ADDR_FLAGS, 8'h00);
    // new value must wait in the hold stage while counting
    wr(ADDR_SNAP_LO, 8'h50);
    cyc(80);
    rd_chk(ADDR_FLAGS, 8'h00);
    wr(ADDR_MODE, 8'h00);
    wr(ADDR_FLAGS, 8'h00);
    wr(ADDR_MODE, 8'h08);
    cyc(100);
    rd_chk(ADDR_FLAGS, 8'h40);
  endtask : t_compare

  task automatic t_channel();
    wr(ADDR_FLAGS, 8'h00);
    @(posedge clk) chi <= 6'h15;
    @(posedge clk) chi <= 6'h00;
    rd_chk(ADDR_FLAGS, 8'h15);
    wr(ADDR_FLAGS, 8'h01);
    rd_chk(ADDR_FLAGS, 8'h01);
    wr(ADDR_MODE, 8'h0e);
    chk({15'h0, irq}, 16'h0);
  endtask : t_channel

  task automatic wait_ovf();
    int i;
    i = 0;
    do begin
      @(negedge clk);
      i++;
    end while (ovf !== 1'b1 && i < 400);
  endtask : wait_ovf

  // 16-bit reload, full wrap, then 8-bit free run keeping the high byte
  task automatic t_wrap16();
    wr(ADDR_MODE, 8'h00);
    wr(ADDR_RLD_HI, 8'hff);
    wr(ADDR_RLD_LO, 8'hf0);
    wr(ADDR_MODE, 8'h58);
    wait_ovf();
    chk(tb, 16'hfff0);
    wr(ADDR_MODE, 8'h08);
    wr(ADDR_FLAGS, 8'h00);
    wait_ovf();
    chk(tb, 16'h0000);
    rd_chk(ADDR_FLAGS, 8'h80);
    wr(ADDR_MODE, 8'h38);
    wait_ovf();
    chk(tb, 16'h0000);
  endtask : t_wrap16

  task automatic tally_and_finish();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    req = '0;
    idle = 1'b0;
    cev = 1'b0;
    chi = 6'h00;
    rst = 1'b1;
    n_fail = 0;
    checks = 0;
    cycles = 0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_prescale();
    t_reload();
    @(posedge clk) idle <= 1'b0;
    t_snap_event(8'h00, 8'hf1);
    t_snap_event(8'h01, 8'h00);
    t_compare();
    t_channel();
    t_wrap16();
    tally_and_finish();
  end
endmodule : counter_array_main_timer_tb
